/* File: verilog/pdm_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - Each channel holds 32-bit current/next pointers and 16-bit current/next counters.
// - Pointer advances by 1, 2 or 4 bytes per unit moved.
// - A rewritten pointer is used from the next unit on, no abort.
// - Current counter counts down per unit and is readable at any time.
// - Counter zero with next zero: stop moving and raise completion flag.
// - Counter zero with next nonzero: load next pair, zero it, carry on.
// - Receive end flag set at zero after memory write; nonzero count write clears.
// - Transmit end flag set at zero after holding load; nonzero count write clears.
// - Receive full flag set when both receive counters are zero.
// - Transmit empty flag set when both transmit counters are zero.
// - Receive ready: take holding register, buffer it, write to memory.
// - Transmit ready: read memory, load the transmit holding register.
// - Full duplex has two channels; half duplex shares one pointer set.
// - Zero current count halts; 1 to 65535 runs while enabled.
// - Command bits switch requests; status shows each enable.
// - Completion and buffer flags are delivered to the peripheral.
// - Enable acts only without its disable; zero bits do nothing.
// - Half duplex: receive enable drops transmit, any disable drops both.
// - Command bits 0,1,8,9; status enables at bits 0 and 8.
module pdm_top #(
	parameter bit HALF_DUPLEX = 1'b0
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	// APB register port
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Peripheral handshakes and holding registers
	input  wire logic [1:0]  xfer_size_i,
	input  wire logic        rx_ready_i,
	input  wire logic [31:0] rx_data_i,
	output logic             rx_take_o,
	input  wire logic        tx_ready_i,
	output logic      [31:0] tx_data_o,
	output logic             tx_load_o,
	// Flags to the peripheral status register
	output logic             receive_end_flag_o,
	output logic             transmit_end_flag_o,
	output logic             receive_buffer_full_flag_o,
	output logic             transmit_buffer_empty_flag_o,
	// Bus matrix master port
	output logic             mem_req_o,
	output logic             mem_write_o,
	output logic      [31:0] mem_addr_o,
	output logic      [1:0]  mem_size_o,
	output logic      [31:0] mem_wdata_o,
	input  wire logic [31:0] mem_rdata_i,
	input  wire logic        mem_ack_i
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Storage slot of a direction; half duplex folds both onto slot 0
	function automatic logic slot(input logic dir);
		return HALF_DUPLEX ? 1'b0 : dir;
	endfunction

	// Byte step of one unit; an undefined size code moves words
	function automatic logic [31:0] step(input logic [1:0] size);
		case (size)
			pdm_pkg::SIZE_BYTE: return 32'h0000_0001;
			pdm_pkg::SIZE_HALF: return 32'h0000_0002;
			default:            return 32'h0000_0004;
		endcase
	endfunction

	// Register offset of a direction: receive base or transmit base
	function automatic logic [7:0] dir_off(input logic dir, input logic [7:0] rx_off,
		input logic [7:0] tx_off);
		return dir ? tx_off : rx_off;
	endfunction

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	pdm_reg_if ifc ();

	pdm_apb_slave u_apb (
		.psel_i    (psel_i),
		.penable_i (penable_i),
		.pwrite_i  (pwrite_i),
		.paddr_i   (paddr_i),
		.pwdata_i  (pwdata_i),
		.prdata_o  (prdata_o),
		.pready_o  (pready_o),
		.pslverr_o (pslverr_o),
		.ifc       (ifc.slave)
	);

	// ------------------------------------------------------------
	// Channel storage
	// ------------------------------------------------------------
	logic [31:0]          ptr_cur [2];
	logic [15:0]          cnt_cur [2];
	logic [31:0]          ptr_nxt [2];
	logic [15:0]          cnt_nxt [2];
	logic [1:0]           en;
	pdm_pkg::pdm_state_t  state;
	logic                 u_dir, u_done;
	logic [1:0]           want, rdy, dir_done, cnt_clr, end_flag, buf_flag;

	assign rdy = {tx_ready_i, rx_ready_i};

	// Unit finished: memory written for receive, holding loaded for transmit
	assign u_done = (state == pdm_pkg::ST_RX_MEM && mem_ack_i)
		| (state == pdm_pkg::ST_TX_LOAD);

	// ------------------------------------------------------------
	// Pointer and counter pairs, one slot per channel
	// ------------------------------------------------------------
	generate
		for (genvar s = 0; s < 2; s++) begin : g_slot
			logic       hw, zero_next;
			logic [1:0] w_cptr, w_ccnt, w_nptr, w_ncnt;

			// Software writes reaching this slot, per direction
			for (genvar d = 0; d < 2; d++) begin : g_dec
				logic hit;
				assign hit = ifc.wr && (slot(d[0]) == s[0]);
				assign w_cptr[d] = hit && ifc.addr == dir_off(d[0],
					pdm_pkg::OFF_RX_CUR_PTR, pdm_pkg::OFF_TX_CUR_PTR);
				assign w_ccnt[d] = hit && ifc.addr == dir_off(d[0],
					pdm_pkg::OFF_RX_CUR_CNT, pdm_pkg::OFF_TX_CUR_CNT);
				assign w_nptr[d] = hit && ifc.addr == dir_off(d[0],
					pdm_pkg::OFF_RX_NXT_PTR, pdm_pkg::OFF_TX_NXT_PTR);
				assign w_ncnt[d] = hit && ifc.addr == dir_off(d[0],
					pdm_pkg::OFF_RX_NXT_CNT, pdm_pkg::OFF_TX_NXT_CNT);
			end

			// Hardware step of this slot and its reload condition
			assign hw        = u_done && (slot(u_dir) == s[0]);
			assign zero_next = (cnt_cur[s] == 16'h0001) && (cnt_nxt[s] != 16'h0000);

			// Current pointer: software write wins, else step or reload
			always_ff @(posedge sys_clk_i) begin
				if (srst_i) begin
					ptr_cur[s] <= pdm_pkg::PTR_RST;
				end else if (|w_cptr) begin
					ptr_cur[s] <= ifc.wdata;
				end else if (hw && zero_next) begin
					ptr_cur[s] <= ptr_nxt[s];
				end else if (hw) begin
					ptr_cur[s] <= ptr_cur[s] + step(mem_size_o);
				end
			end

			// Current counter: count down per unit, reload from next pair
			always_ff @(posedge sys_clk_i) begin
				if (srst_i) begin
					cnt_cur[s] <= pdm_pkg::CNT_RST;
				end else if (|w_ccnt) begin
					cnt_cur[s] <= ifc.wdata[15:0];
				end else if (hw && zero_next) begin
					cnt_cur[s] <= cnt_nxt[s];
				end else if (hw) begin
					cnt_cur[s] <= cnt_cur[s] - 16'h0001;
				end
			end

			// Next pair: cleared once copied into the current pair
			always_ff @(posedge sys_clk_i) begin
				if (srst_i) begin
					ptr_nxt[s] <= pdm_pkg::PTR_RST;
					cnt_nxt[s] <= pdm_pkg::CNT_RST;
				end else begin
					if (|w_nptr) begin
						ptr_nxt[s] <= ifc.wdata;
					end else if (hw && zero_next) begin
						ptr_nxt[s] <= pdm_pkg::PTR_RST;
					end
					if (|w_ncnt) begin
						cnt_nxt[s] <= ifc.wdata[15:0];
					end else if (hw && zero_next) begin
						cnt_nxt[s] <= pdm_pkg::CNT_RST;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Flags per direction
	// ------------------------------------------------------------
	generate
		for (genvar f = 0; f < 2; f++) begin : g_flag
			// Nonzero write to either counter of this direction
			assign cnt_clr[f] = ifc.wr && (ifc.wdata[15:0] != 16'h0000)
				&& (ifc.addr == dir_off(f[0], pdm_pkg::OFF_RX_CUR_CNT,
				pdm_pkg::OFF_TX_CUR_CNT) || ifc.addr == dir_off(f[0],
				pdm_pkg::OFF_RX_NXT_CNT, pdm_pkg::OFF_TX_NXT_CNT));
			assign dir_done[f] = u_done && (u_dir == f[0]);

			pdm_flag u_flag (
				.sys_clk_i  (sys_clk_i),
				.srst_i     (srst_i),
				.done_i     (dir_done[f]),
				.last_i     (cnt_cur[slot(f[0])] == 16'h0001),
				.nxt_zero_i (cnt_nxt[slot(f[0])] == 16'h0000),
				.clr_i      (cnt_clr[f]),
				.end_o      (end_flag[f]),
				.buf_o      (buf_flag[f])
			);
		end
	endgenerate

	// Flags go to the peripheral only
	assign receive_end_flag_o           = end_flag[pdm_pkg::DIR_RX];
	assign transmit_end_flag_o          = end_flag[pdm_pkg::DIR_TX];
	assign receive_buffer_full_flag_o   = buf_flag[pdm_pkg::DIR_RX];
	assign transmit_buffer_empty_flag_o = buf_flag[pdm_pkg::DIR_TX];

	// ------------------------------------------------------------
	// Request enables
	// ------------------------------------------------------------
	logic w_cmd, rx_on, rx_off, tx_on, tx_off;

	// Enable counts only if its own disable is not written with it
	assign w_cmd  = ifc.wr && (ifc.addr == pdm_pkg::OFF_COMMAND);
	assign rx_off = w_cmd && ifc.wdata[pdm_pkg::CMD_RX_DIS];
	assign tx_off = w_cmd && ifc.wdata[pdm_pkg::CMD_TX_DIS];
	assign rx_on  = w_cmd && ifc.wdata[pdm_pkg::CMD_RX_EN] && !rx_off;
	assign tx_on  = w_cmd && ifc.wdata[pdm_pkg::CMD_TX_EN] && !tx_off;

	// Enable register; half duplex keeps the two exclusive
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			en <= pdm_pkg::EN_RST;
		end else if (HALF_DUPLEX) begin
			if (rx_off || tx_off) begin
				en <= 2'h0;
			end else if (rx_on) begin
				en <= 2'h1;
			end else if (tx_on) begin
				en <= 2'h2;
			end
		end else begin
			if (rx_off) begin
				en[pdm_pkg::DIR_RX] <= 1'b0;
			end else if (rx_on) begin
				en[pdm_pkg::DIR_RX] <= 1'b1;
			end
			if (tx_off) begin
				en[pdm_pkg::DIR_TX] <= 1'b0;
			end else if (tx_on) begin
				en[pdm_pkg::DIR_TX] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------
	// Unmapped offsets answer with an error
	always_comb begin
		case (ifc.addr)
			pdm_pkg::OFF_RX_CUR_PTR, pdm_pkg::OFF_RX_CUR_CNT,
			pdm_pkg::OFF_TX_CUR_PTR, pdm_pkg::OFF_TX_CUR_CNT,
			pdm_pkg::OFF_RX_NXT_PTR, pdm_pkg::OFF_RX_NXT_CNT,
			pdm_pkg::OFF_TX_NXT_PTR, pdm_pkg::OFF_TX_NXT_CNT,
			pdm_pkg::OFF_COMMAND, pdm_pkg::OFF_STATUS: ifc.err = 1'b0;
			default:                                   ifc.err = 1'b1;
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ifc.rdata <= 32'h0000_0000;
		end else if (ifc.rd) begin
			case (ifc.addr)
				pdm_pkg::OFF_RX_CUR_PTR: ifc.rdata <= ptr_cur[slot(pdm_pkg::DIR_RX)];
				pdm_pkg::OFF_RX_CUR_CNT: ifc.rdata <= {16'h0000, cnt_cur[slot(pdm_pkg::DIR_RX)]};
				pdm_pkg::OFF_TX_CUR_PTR: ifc.rdata <= ptr_cur[slot(pdm_pkg::DIR_TX)];
				pdm_pkg::OFF_TX_CUR_CNT: ifc.rdata <= {16'h0000, cnt_cur[slot(pdm_pkg::DIR_TX)]};
				pdm_pkg::OFF_RX_NXT_PTR: ifc.rdata <= ptr_nxt[slot(pdm_pkg::DIR_RX)];
				pdm_pkg::OFF_RX_NXT_CNT: ifc.rdata <= {16'h0000, cnt_nxt[slot(pdm_pkg::DIR_RX)]};
				pdm_pkg::OFF_TX_NXT_PTR: ifc.rdata <= ptr_nxt[slot(pdm_pkg::DIR_TX)];
				pdm_pkg::OFF_TX_NXT_CNT: ifc.rdata <= {16'h0000, cnt_nxt[slot(pdm_pkg::DIR_TX)]};
				pdm_pkg::OFF_STATUS: begin
					ifc.rdata                      <= 32'h0000_0000;
					ifc.rdata[pdm_pkg::STAT_RX_EN] <= en[pdm_pkg::DIR_RX];
					ifc.rdata[pdm_pkg::STAT_TX_EN] <= en[pdm_pkg::DIR_TX];
				end
				default: ifc.rdata <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Mover
	// ------------------------------------------------------------
	// A direction is served while enabled, counting and ready
	always_comb begin
		for (int d = 0; d < 2; d++) begin
			want[d] = en[d] && (cnt_cur[slot(d[0])] != 16'h0000) && rdy[d];
		end
	end

	// Sequence: receive takes priority over transmit when both ask
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state       <= pdm_pkg::ST_IDLE;
			u_dir       <= pdm_pkg::DIR_RX;
			rx_take_o   <= 1'b0;
			tx_load_o   <= 1'b0;
			tx_data_o   <= 32'h0000_0000;
			mem_req_o   <= 1'b0;
			mem_write_o <= 1'b0;
			mem_addr_o  <= 32'h0000_0000;
			mem_size_o  <= 2'h0;
			mem_wdata_o <= 32'h0000_0000;
		end else begin
			rx_take_o <= 1'b0;
			tx_load_o <= 1'b0;
			case (state)
				pdm_pkg::ST_IDLE: begin
					mem_size_o <= xfer_size_i;
					if (want[pdm_pkg::DIR_RX]) begin
						u_dir       <= pdm_pkg::DIR_RX;
						rx_take_o   <= 1'b1;
						mem_req_o   <= 1'b1;
						mem_write_o <= 1'b1;
						mem_addr_o  <= ptr_cur[slot(pdm_pkg::DIR_RX)];
						mem_wdata_o <= rx_data_i;
						state       <= pdm_pkg::ST_RX_MEM;
					end else if (want[pdm_pkg::DIR_TX]) begin
						u_dir       <= pdm_pkg::DIR_TX;
						mem_req_o   <= 1'b1;
						mem_write_o <= 1'b0;
						mem_addr_o  <= ptr_cur[slot(pdm_pkg::DIR_TX)];
						state       <= pdm_pkg::ST_TX_MEM;
					end
				end
				pdm_pkg::ST_RX_MEM: begin
					if (mem_ack_i) begin
						mem_req_o <= 1'b0;
						state     <= pdm_pkg::ST_IDLE;
					end
				end
				pdm_pkg::ST_TX_MEM: begin
					if (mem_ack_i) begin
						mem_req_o <= 1'b0;
						tx_data_o <= mem_rdata_i;
						tx_load_o <= 1'b1;
						state     <= pdm_pkg::ST_TX_LOAD;
					end
				end
				pdm_pkg::ST_TX_LOAD: begin
					state <= pdm_pkg::ST_IDLE;
				end
				default: state <= pdm_pkg::ST_IDLE;
			endcase
		end
	end

endmodule

/* File: verilog/pdm_pkg.sv */
package pdm_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PTR_W  = 32;
	localparam int unsigned CNT_W  = 16;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_RX_CUR_PTR = 8'h00;
	localparam logic [7:0] OFF_RX_CUR_CNT = 8'h04;
	localparam logic [7:0] OFF_TX_CUR_PTR = 8'h08;
	localparam logic [7:0] OFF_TX_CUR_CNT = 8'h0C;
	localparam logic [7:0] OFF_RX_NXT_PTR = 8'h10;
	localparam logic [7:0] OFF_RX_NXT_CNT = 8'h14;
	localparam logic [7:0] OFF_TX_NXT_PTR = 8'h18;
	localparam logic [7:0] OFF_TX_NXT_CNT = 8'h1C;
	localparam logic [7:0] OFF_COMMAND    = 8'h20;
	localparam logic [7:0] OFF_STATUS     = 8'h24;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int unsigned CMD_RX_EN  = 0;
	localparam int unsigned CMD_RX_DIS = 1;
	localparam int unsigned CMD_TX_EN  = 8;
	localparam int unsigned CMD_TX_DIS = 9;
	localparam int unsigned STAT_RX_EN = 0;
	localparam int unsigned STAT_TX_EN = 8;
	localparam logic [31:0] PTR_RST   = 32'h0000_0000;
	localparam logic [15:0] CNT_RST   = 16'h0000;
	localparam logic [1:0]  EN_RST    = 2'h0;

	// ------------------------------------------------------------
	// Directions, unit sizes and mover states
	// ------------------------------------------------------------
	localparam logic DIR_RX = 1'b0;
	localparam logic DIR_TX = 1'b1;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_RX_MEM  = 2'b01,
		ST_TX_MEM  = 2'b10,
		ST_TX_LOAD = 2'b11
	} pdm_state_t;

endpackage

/* File: verilog/pdm_reg_if.sv */
`timescale 1ns/1ps
interface pdm_reg_if;
	// Register access strobes from the bus slave
	logic        wr;
	logic        rd;
	logic [7:0]  addr;
	logic [31:0] wdata;
	// Answer from the register file
	logic [31:0] rdata;
	logic        err;

	modport slave (output wr, rd, addr, wdata, input rdata, err);
	modport regs  (input wr, rd, addr, wdata, output rdata, err);
endinterface

/* File: verilog/pdm_apb_slave.sv */
`timescale 1ns/1ps
module pdm_apb_slave (
	// APB slave port
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Register file side
	pdm_reg_if.slave         ifc
);

	// ------------------------------------------------------------
	// Strobes
	// ------------------------------------------------------------
	// Read data is captured during setup, so access needs no wait
	assign ifc.rd    = psel_i & ~penable_i & ~pwrite_i;
	assign ifc.wr    = psel_i & penable_i & pwrite_i;
	assign ifc.addr  = paddr_i;
	assign ifc.wdata = pwdata_i;

	// ------------------------------------------------------------
	// Answer
	// ------------------------------------------------------------
	// Zero wait states; unmapped access flagged in access phase
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ifc.err;
	assign prdata_o  = ifc.rdata;

endmodule

/* File: verilog/pdm_flag.sv */
`timescale 1ns/1ps
module pdm_flag (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic srst_i,
	// Events
	input  wire logic done_i,
	input  wire logic last_i,
	input  wire logic nxt_zero_i,
	input  wire logic clr_i,
	// Flags
	output logic      end_o,
	output logic      buf_o
);

	// End flag: set on last unit of current pair, set wins over clear
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			end_o <= 1'b0;
		end else if (done_i && last_i) begin
			end_o <= 1'b1;
		end else if (clr_i) begin
			end_o <= 1'b0;
		end
	end

	// Buffer flag: set when no next pair is waiting either
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			buf_o <= 1'b0;
		end else if (done_i && last_i && nxt_zero_i) begin
			buf_o <= 1'b1;
		end else if (clr_i) begin
			buf_o <= 1'b0;
		end
	end

endmodule

/* File: tb/pdm_monitor.sv */
`timescale 1ns/1ps
module pdm_monitor (
	// Clock, reset and bus
	input wire logic        sys_clk_i,
	input wire logic        srst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic [7:0]  paddr_i,
	input wire logic        pslverr_o,
	// Peripheral side
	input wire logic [1:0]  xfer_size_i,
	input wire logic        rx_take_o,
	input wire logic [31:0] tx_data_o,
	input wire logic        tx_load_o,
	input wire logic        receive_end_flag_o,
	input wire logic        transmit_end_flag_o,
	input wire logic        receive_buffer_full_flag_o,
	// Memory side
	input wire logic        mem_req_o,
	input wire logic        mem_write_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [1:0]  mem_size_o,
	input wire logic [31:0] mem_rdata_i,
	input wire logic        mem_ack_i
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// ----------------------------------------
	// Bus and handshake checks
	// ----------------------------------------
	unmapped_err_a: assert property (psel_i && penable_i && paddr_i > 8'h24 |-> pslverr_o)
		else $error("unmapped offset gave no error");
	req_hold_a: assert property (mem_req_o && !mem_ack_i |=>
		mem_req_o && $stable(mem_addr_o) && $stable(mem_write_o))
		else $error("memory request changed before ack");
	take_pulse_a: assert property (rx_take_o |=> !rx_take_o)
		else $error("holding read longer than one cycle");
	take_write_a: assert property (rx_take_o |-> mem_req_o && mem_write_o)
		else $error("holding read without memory write");
	load_data_a: assert property (mem_req_o && mem_ack_i && !mem_write_o && xfer_size_i == 2'h2
		|=> tx_load_o && tx_data_o == $past(mem_rdata_i))
		else $error("memory word not loaded to holding");
	load_cause_a: assert property (tx_load_o |-> $past(mem_ack_i && !mem_write_o))
		else $error("holding load without memory read");
	unit_size_a: assert property (mem_req_o && xfer_size_i != 2'h3 |-> mem_size_o == xfer_size_i)
		else $error("access width differs from unit size");
	// ----------------------------------------
	// Flag checks
	// ----------------------------------------
	rx_end_a: assert property ($rose(receive_end_flag_o) |->
		$past(mem_req_o && mem_ack_i && mem_write_o))
		else $error("receive end without memory write");
	tx_end_a: assert property ($rose(transmit_end_flag_o) |-> $past(tx_load_o))
		else $error("transmit end without holding load");
	rx_full_a: assert property ($rose(receive_buffer_full_flag_o) |-> receive_end_flag_o)
		else $error("buffer full without receive end");
	cover property (rx_take_o);
	cover property (tx_load_o);
	cover property ($rose(receive_buffer_full_flag_o));
endmodule

bind pdm_top pdm_monitor mon_u (.sys_clk_i, .srst_i, .psel_i, .penable_i, .paddr_i, .pslverr_o,
	.xfer_size_i, .rx_take_o, .tx_data_o, .tx_load_o, .receive_end_flag_o,
	.transmit_end_flag_o, .receive_buffer_full_flag_o, .mem_req_o, .mem_write_o,
	.mem_addr_o, .mem_size_o, .mem_rdata_i, .mem_ack_i);

/* File: tb/pdm_periph_model.sv */
`timescale 1ns/1ps
module pdm_periph_model (
	// Clock, reset and test controls
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic        rx_want_i,
	input  wire logic        tx_want_i,
	input  wire logic        slow_i,
	// Channel outputs
	input  wire logic        rx_take_i,
	input  wire logic        tx_load_i,
	input  wire logic        mem_req_i,
	input  wire logic [31:0] mem_addr_i,
	// Answers
	output logic             rx_ready_o,
	output logic      [31:0] rx_data_o,
	output logic             tx_ready_o,
	output logic      [31:0] mem_rdata_o,
	output logic             mem_ack_o
);
	logic [31:0] rx_val;
	logic [1:0]  wait_cnt;
	// Receive ready held until taken, new value per unit
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rx_ready_o <= 1'b0;
			rx_val     <= 32'h1357_9BDF;
		end else if (rx_take_i) begin
			rx_ready_o <= 1'b0;
			rx_val     <= rx_val + 32'h0102_0304;
		end else if (rx_want_i) begin
			rx_ready_o <= 1'b1;
		end
	end
	assign rx_data_o = rx_ready_o ? rx_val : ~rx_val; // Released value is inverted
	// Transmit ready held until loaded
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || tx_load_i) begin
			tx_ready_o <= 1'b0;
		end else if (tx_want_i) begin
			tx_ready_o <= 1'b1;
		end
	end
	// Memory answers promptly or after three waits
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mem_ack_o <= 1'b0;
			wait_cnt  <= 2'h0;
		end else if (mem_ack_o) begin
			mem_ack_o <= 1'b0;
			wait_cnt  <= slow_i ? 2'h3 : 2'h0;
		end else if (mem_req_i) begin
			if (wait_cnt == 2'h0) begin
				mem_ack_o <= 1'b1;
			end else begin
				wait_cnt <= wait_cnt - 2'h1;
			end
		end
	end
	assign mem_rdata_o = mem_ack_o ? {mem_addr_i[15:0], ~mem_addr_i[15:0]}
		: {~mem_addr_i[15:0], mem_addr_i[15:0]};
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        sys_clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er_v;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, rx_data_i, tx_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic [31:0] rd_v, p0, p1, st;
	logic [1:0]  xfer_size_i, mem_size_o, sz;
	logic        rx_ready_i, rx_take_o, tx_ready_i, tx_load_o, mem_req_o, mem_write_o, mem_ack_i;
	logic        rx_end, tx_end, rx_full, tx_empty, rx_want, tx_want, slow;
	int          fails, n_tests, i;
	logic [31:0] q_addr[$], q_tx[$], q_wd[$];

	initial sys_clk_i = 1'b0;
	always #25 sys_clk_i = ~sys_clk_i;

	pdm_top dut_u (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .xfer_size_i, .rx_ready_i, .rx_data_i, .rx_take_o,
		.tx_ready_i, .tx_data_o, .tx_load_o, .receive_end_flag_o(rx_end),
		.transmit_end_flag_o(tx_end), .receive_buffer_full_flag_o(rx_full),
		.transmit_buffer_empty_flag_o(tx_empty), .mem_req_o, .mem_write_o, .mem_addr_o,
		.mem_size_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i);
	pdm_periph_model peer_u (.sys_clk_i, .srst_i, .rx_want_i(rx_want), .tx_want_i(tx_want),
		.slow_i(slow), .rx_take_i(rx_take_o), .tx_load_i(tx_load_o), .mem_req_i(mem_req_o),
		.mem_addr_i(mem_addr_o), .rx_ready_o(rx_ready_i), .rx_data_o(rx_data_i),
		.tx_ready_o(tx_ready_i), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));

	// Log finished memory units and holding loads
	always @(posedge sys_clk_i) begin
		if (mem_req_o && mem_ack_i) q_addr.push_back(mem_addr_o);
		if (tx_load_o) q_tx.push_back(tx_data_o);
		if (mem_write_o && mem_ack_i) q_wd.push_back(mem_wdata_o);
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] step(input logic [1:0] s);
		return (s == 2'h0) ? 32'h1 : (s == 2'h1) ? 32'h2 : 32'h4;
	endfunction
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One APB transfer: setup, access until pready, then release
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		rd_v = prdata_o;
		er_v = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 50) begin fails++; report_and_stop; end
		@(posedge sys_clk_i);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		`CHK(nm, ex, rd_v);
	endtask
	task automatic wait_flag(input bit tx);
		int n;
		n = 0;
		while ((tx ? tx_empty : rx_full) !== 1'b1 && n < 400) begin @(posedge sys_clk_i); n++; end
		if (n >= 400) begin fails++; report_and_stop; end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(81393));
		{srst_i, psel_i, penable_i, pwrite_i, rx_want, tx_want, slow} = 7'h40;
		{paddr_i, pwdata_i, xfer_size_i} = '0;
		repeat (5) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		@(posedge sys_clk_i);
		// Reset values, unmapped offset, counter width
		for (i = 0; i < 10; i++) rchk("reset value", 8'(i * 4), 32'h0);
		apb(1'b0, 8'h28, 32'h0);
		`CHK("unmapped error", 1'b1, er_v);
		apb(1'b1, pdm_pkg::OFF_RX_CUR_CNT, 32'hFFFF_FFFF);
		rchk("count width", pdm_pkg::OFF_RX_CUR_CNT, 32'h0000_FFFF);
		$display("test registers done");
		// Receive three units then reload two, random size and memory speed
		sz = 2'($urandom_range(2));
		xfer_size_i <= sz;
		slow <= 1'($urandom_range(1));
		p0 = $urandom & 32'hFFFF_FFFC;
		p1 = $urandom & 32'hFFFF_FFFC;
		st = step(sz);
		apb(1'b1, pdm_pkg::OFF_RX_CUR_PTR, p0);
		apb(1'b1, pdm_pkg::OFF_RX_CUR_CNT, 32'h3);
		apb(1'b1, pdm_pkg::OFF_RX_NXT_PTR, p1);
		apb(1'b1, pdm_pkg::OFF_RX_NXT_CNT, 32'h2);
		q_addr.delete();
		rx_want <= 1'b1;
		apb(1'b1, pdm_pkg::OFF_COMMAND, 32'h1);
		rchk("rx enabled", pdm_pkg::OFF_STATUS, 32'h1);
		wait_flag(1'b0);
		repeat (20) @(posedge sys_clk_i);
		`CHK("unit count", 32'd5, 32'(q_addr.size()));
		for (i = 0; i < 5; i++) `CHK("mem address", (i < 3) ? p0 + i * st : p1 + (i - 3) * st, q_addr[i]);
		for (i = 0; i < 5; i++) `CHK("rx data", 32'h1357_9BDF + i * 32'h0102_0304, q_wd[i]);
		`CHK("rx end flag", 1'b1, rx_end);
		rchk("rx pointer", pdm_pkg::OFF_RX_CUR_PTR, p1 + 2 * st);
		rchk("rx count", pdm_pkg::OFF_RX_CUR_CNT, 32'h0);
		rchk("rx next count", pdm_pkg::OFF_RX_NXT_CNT, 32'h0);
		rx_want <= 1'b0;
		// Disable, then a nonzero next count clears both receive flags
		apb(1'b1, pdm_pkg::OFF_COMMAND, 32'h2);
		rchk("rx disabled", pdm_pkg::OFF_STATUS, 32'h0);
		apb(1'b1, pdm_pkg::OFF_RX_NXT_CNT, 32'h1);
		`CHK("rx end cleared", 1'b0, rx_end);
		`CHK("rx full cleared", 1'b0, rx_full);
		$display("test receive done");
		// Transmit two words; enable with its disable is refused
		xfer_size_i <= 2'h2;
		p0 = $urandom & 32'hFFFF_FFFC;
		apb(1'b1, pdm_pkg::OFF_TX_CUR_PTR, p0);
		apb(1'b1, pdm_pkg::OFF_TX_CUR_CNT, 32'h2);
		apb(1'b1, pdm_pkg::OFF_COMMAND, 32'h300);
		rchk("tx enable and disable", pdm_pkg::OFF_STATUS, 32'h0);
		q_tx.delete();
		tx_want <= 1'b1;
		apb(1'b1, pdm_pkg::OFF_COMMAND, 32'h100);
		rchk("tx enabled", pdm_pkg::OFF_STATUS, 32'h100);
		wait_flag(1'b1);
		tx_want <= 1'b0;
		`CHK("tx units", 32'd2, 32'(q_tx.size()));
		for (i = 0; i < 2; i++) `CHK("tx data", pat(p0 + 4 * i), q_tx[i]);
		`CHK("tx end flag", 1'b1, tx_end);
		`CHK("tx empty flag", 1'b1, tx_empty);
		$display("test transmit done");
		report_and_stop;
	end
endmodule
